// >>> dsgate_top.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - each gate bit enables one unit clock
// - access to gated-off unit gets bus fault
// - gate bits reset to zero
// - three gate registers chosen by mode
// - sleep registers apply only with auto gating
// - pwm bit20, converter bit16, watchdog bit3
// - deep-sleep gate register at offset 0x120
module dsgate_top (
  // clock and reset
  input  wire logic                           REF_CLK,
  input  wire logic                           RST_B,
  // register bus, AHB-Lite slave side
  input  wire logic                           HSEL,
  input  wire logic [31:0]                    HADDR,
  input  wire logic [1:0]                     HTRANS,
  input  wire logic                           HWRITE,
  input  wire logic [2:0]                     HSIZE,
  input  wire logic [31:0]                    HWDATA,
  input  wire logic                           HREADY,
  output logic      [31:0]                    HRDATA,
  output logic                                HREADYOUT,
  output logic                                HRESP,
  // operating mode of the system
  input  wire logic [1:0]                     MODE,
  // unit accesses from the peripheral side and their outcome
  input  wire logic [dsgate_pkg::N_UNITS-1:0] UNIT_SEL,
  input  wire logic                           UNIT_ACC,
  output logic                                UNIT_FAULT,
  // clock enables and the fault interrupt
  output logic      [dsgate_pkg::N_UNITS-1:0] UNIT_CLK_EN,
  output logic                                IRQ
);

  // unit count of every gating word and of the fault bits
  localparam int N_U = dsgate_pkg::N_UNITS;

  // register that an address phase points at; all eight codes are
  // in use, so a case over them needs no default
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_RUN   = 3'b001,
    SEL_SLEEP = 3'b010,
    SEL_DEEP  = 3'b011,
    SEL_CFG   = 3'b100,
    SEL_MODE  = 3'b101,
    SEL_FSTAT = 3'b110,
    SEL_FMASK = 3'b111
  } dsgate_sel_t;

  // whole state of the block: the gating and configuration words, the
  // fault status and mask, the error response pair, the read data
  // register and the pending address phase; s_nxt is its next value
  dsgate_pkg::dsgate_state_t s_r;
  dsgate_pkg::dsgate_state_t s_nxt;

  // mode selection, unit terms and bus decode
  // (all combinational, feeding the outputs and the single next-state process)
  logic           auto_on;
  logic [31:0]    act_gate;
  logic [N_U-1:0] en;
  logic [N_U-1:0] faults;
  logic           aph_ok;
  dsgate_sel_t    wr_sel;
  dsgate_sel_t    rd_sel;
  logic [31:0]    rd_word;

  // fault status clear pattern and next status
  logic [N_U-1:0] stat_clr;
  logic [N_U-1:0] stat_nxt;

  // write strobes, one for each register that software can change
  logic           wr_run;
  logic           wr_sleep;
  logic           wr_deep;
  logic           wr_cfg;
  logic           wr_fmask;
  logic           wr_fstat;

  // one decode for both the write and the read path, so the two can
  // never disagree on the map; offsets outside it fall to SEL_NONE
  function automatic dsgate_sel_t dsg_decode(input logic [11:0] a);
    dsgate_sel_t sel;
    sel = SEL_NONE;
    unique case (a)
      dsgate_pkg::RUN_GATE_OFF: begin
        sel = SEL_RUN;
      end
      dsgate_pkg::SLEEP_GATE_OFF: begin
        sel = SEL_SLEEP;
      end
      dsgate_pkg::DEEP_GATE_OFF: begin
        sel = SEL_DEEP;
      end
      dsgate_pkg::RUN_CFG_OFF: begin
        sel = SEL_CFG;
      end
      dsgate_pkg::MODE_OFF: begin
        sel = SEL_MODE;
      end
      dsgate_pkg::FAULT_STAT_OFF: begin
        sel = SEL_FSTAT;
      end
      dsgate_pkg::FAULT_MASK_OFF: begin
        sel = SEL_FMASK;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // keeps only the writable enables of a gating word; reserved bits
  // read back as zero once software has written the register
  function automatic logic [31:0] dsg_gate_word(input logic [31:0] w);
    return w & dsgate_pkg::GATE_MASK;
  endfunction

  // widens a per-unit bit set to a bus word, units in the low bits
  function automatic logic [31:0] dsg_unit_word(input logic [N_U-1:0] b);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[N_U-1:0] = b;
    return w;
  endfunction

  // bit of a gating word that holds the enable of unit idx; units are
  // counted from the watchdog end: 0 watchdog, 1 converter, 2 pwm,
  // the same order as the fault status bits
  function automatic int dsg_unit_pos(input int idx);
    int pos;
    pos = dsgate_pkg::PWM_BIT;
    case (idx)
      0: begin
        pos = dsgate_pkg::WDOG_BIT;
      end
      1: begin
        pos = dsgate_pkg::CONV_BIT;
      end
      default: begin
        pos = dsgate_pkg::PWM_BIT;
      end
    endcase
    return pos;
  endfunction

  // the automatic gating bit of the run clock configuration word
  assign auto_on = s_r.run_cfg[dsgate_pkg::AUTO_BIT];

  // gate word chosen by operating mode; with auto gating off the run
  // word stays in force in every mode, so a sleep entry cannot starve
  // a unit that software left running; the undefined mode code acts
  // as run rather than switching every unit off
  always_comb begin
    act_gate = s_r.run_gate;
    if (auto_on) begin
      unique case (MODE)
        dsgate_pkg::DSG_SLEEP: begin
          act_gate = s_r.sleep_gate;
        end
        dsgate_pkg::DSG_DEEP: begin
          act_gate = s_r.deep_gate;
        end
        default: begin
          act_gate = s_r.run_gate;
        end
      endcase
    end
  end

  // one enable and one fault term per unit; a unit's fault only rises
  // while it is addressed, so an idle access strobe never faults;
  // the enable follows the mode at once, with no clock of delay
  for (genvar gi = 0; gi < N_U; gi++) begin : g_unit
    // position of this unit's enable in the gating word
    localparam int POS = dsg_unit_pos(gi);
    assign en[gi]     = act_gate[POS];
    assign faults[gi] = UNIT_ACC & UNIT_SEL[gi] & ~act_gate[POS];
  end

  // enables leave the block straight from the selected word
  assign UNIT_CLK_EN = en;
  // any access to a unit whose clock is off is refused
  assign UNIT_FAULT  = |faults;
  // level interrupt while an unmasked fault bit is set; it comes from
  // registered bits only, so it cannot glitch with the access strobe
  assign IRQ         = |(s_r.fault_stat & s_r.fault_mask);

  // bus timing: the address phase is taken at an edge, a write's data
  // phase follows in the next cycle and lands at the edge that ends it;
  // a read's word is registered at the address edge and stands on
  // HRDATA through the data phase and until the next read, with no
  // wait state either way
  //
  // the transfer size is not checked: every access moves a whole word;
  // the upper address bits are left to the system bus decoder
  assign aph_ok = HSEL && HREADY && HTRANS[1];

  // decode of the pending write
  assign wr_sel = dsg_decode(s_r.aph.addr);
  // decode of the read being taken
  assign rd_sel = dsg_decode(HADDR[11:0]);

  // write strobes, high in the data phase of a write that was taken
  // at the edge before; the mode register is read-only
  assign wr_run   = s_r.aph.wr_pend && (wr_sel == SEL_RUN);
  assign wr_sleep = s_r.aph.wr_pend && (wr_sel == SEL_SLEEP);
  assign wr_deep  = s_r.aph.wr_pend && (wr_sel == SEL_DEEP);
  assign wr_cfg   = s_r.aph.wr_pend && (wr_sel == SEL_CFG);
  assign wr_fmask = s_r.aph.wr_pend && (wr_sel == SEL_FMASK);
  assign wr_fstat = s_r.aph.wr_pend && (wr_sel == SEL_FSTAT);

  // error response takes two cycles per protocol; OKAY is one, and
  // only OKAY is ever produced by this register set
  assign HREADYOUT = ~(s_r.resp_err & ~s_r.err_2nd);
  assign HRESP     = s_r.resp_err;
  // read data come from a flip-flop and stand until the next read
  assign HRDATA    = s_r.rdata;

  // read word of the register being addressed; it is taken into the
  // read data register at the address edge, so the data phase sees
  // a settled flip-flop rather than this mux
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_sel)
      SEL_RUN: begin
        rd_word = s_r.run_gate;
      end
      SEL_SLEEP: begin
        rd_word = s_r.sleep_gate;
      end
      SEL_DEEP: begin
        rd_word = s_r.deep_gate;
      end
      SEL_CFG: begin
        rd_word = s_r.run_cfg;
      end
      SEL_MODE: begin
        rd_word[1:0] = MODE;
      end
      SEL_FSTAT: begin
        rd_word = dsg_unit_word(s_r.fault_stat);
      end
      SEL_FMASK: begin
        rd_word = dsg_unit_word(s_r.fault_mask);
      end
      SEL_NONE: begin
        rd_word = 32'h0000_0000;                      // unmapped reads return zero
      end
    endcase
  end

  // write-one-to-clear pattern of the fault status, present only in
  // the data phase of a write aimed at the status register
  always_comb begin
    stat_clr = '0;
    if (wr_fstat) begin
      stat_clr = HWDATA[N_U-1:0];
    end
  end

  // a fault in the same cycle as its clear wins, so no event is lost;
  // software that clears a bit which sets again sees it still set
  assign stat_nxt = (s_r.fault_stat & ~stat_clr) | faults;

  // next state of the whole block; every field not named below keeps
  // its value from the copy taken at the top
  always_comb begin
    s_nxt = s_r;
    // sticky fault bits, set by refused accesses
    s_nxt.fault_stat = stat_nxt;
    // the error response, if ever raised, ends after its second cycle
    // and blocks new address phases while it runs
    if (s_r.resp_err) begin
      s_nxt.err_2nd = ~s_r.err_2nd;
    end
    if (s_r.resp_err && s_r.err_2nd) begin
      s_nxt.resp_err = 1'b0;
    end
    // gating words keep only their enables; a write clears the reserved bits
    if (wr_run) begin
      s_nxt.run_gate = dsg_gate_word(HWDATA);
    end
    if (wr_sleep) begin
      s_nxt.sleep_gate = dsg_gate_word(HWDATA);
    end
    if (wr_deep) begin
      s_nxt.deep_gate = dsg_gate_word(HWDATA);
    end
    // only the auto gating bit of the configuration word is writable
    if (wr_cfg) begin
      s_nxt.run_cfg = HWDATA & dsgate_pkg::RUN_CFG_MASK;
    end
    // mask bits of the fault interrupt
    if (wr_fmask) begin
      s_nxt.fault_mask = HWDATA[N_U-1:0];
    end
    // a new address phase replaces the one just finished
    s_nxt.aph.wr_pend = 1'b0;
    if (aph_ok && !s_r.resp_err) begin
      s_nxt.aph.addr = HADDR[11:0];
      if (HWRITE) begin
        s_nxt.aph.wr_pend = 1'b1;
      end else begin
        s_nxt.rdata = rd_word;
      end
    end
  end

  // one register for all state; the deep-sleep word powers up with
  // its printed reset pattern, which holds no unit enable, so every
  // unit starts unclocked; the error pair and read register start idle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r.run_gate   <= dsgate_pkg::GATE_RST;
      s_r.sleep_gate <= dsgate_pkg::GATE_RST;
      s_r.deep_gate  <= dsgate_pkg::DEEP_GATE_RST;
      s_r.run_cfg    <= dsgate_pkg::RUN_CFG_RST;
      s_r.fault_stat <= dsgate_pkg::FAULT_RST;
      s_r.fault_mask <= dsgate_pkg::FAULT_RST;
      s_r.resp_err   <= 1'b0;
      s_r.err_2nd    <= 1'b0;
      s_r.rdata      <= 32'h0000_0000;
      s_r.aph        <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> dsgate_pkg.sv
package dsgate_pkg;

  // bus offsets (byte addresses)
  localparam logic [11:0] RUN_GATE_OFF   = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFF  = 12'h120;
  localparam logic [11:0] RUN_CFG_OFF    = 12'h060;
  localparam logic [11:0] MODE_OFF       = 12'h130;
  localparam logic [11:0] FAULT_STAT_OFF = 12'h140;
  localparam logic [11:0] FAULT_MASK_OFF = 12'h144;

  // gate and auto bit positions, unit count
  localparam int PWM_BIT   = 20;
  localparam int CONV_BIT  = 16;
  localparam int WDOG_BIT  = 3;
  localparam int AUTO_BIT  = 27;
  localparam int N_UNITS   = 3;

  // writable bits and reset values of the gating, configuration and fault registers
  localparam logic [31:0] GATE_MASK      = 32'h0011_0008;
  localparam logic [31:0] GATE_RST       = 32'h0000_0000;
  localparam logic [31:0] DEEP_GATE_RST  = 32'h0000_0040;
  localparam logic [31:0] RUN_CFG_MASK   = 32'h0800_0000;
  localparam logic [31:0] RUN_CFG_RST    = 32'h0000_0000;
  localparam logic [2:0]  FAULT_RST      = 3'h0;

  typedef enum logic [1:0] {
    DSG_RUN   = 2'b00,
    DSG_SLEEP = 2'b01,
    DSG_DEEP  = 2'b10
  } dsgate_mode_t;

  // one registered AHB-Lite address phase
  typedef struct packed {
    logic        wr_pend;
    logic [11:0] addr;
  } dsgate_aph_t;

  typedef struct packed {
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] run_cfg;
    logic [N_UNITS-1:0] fault_stat;
    logic [N_UNITS-1:0] fault_mask;
    logic        resp_err;
    logic        err_2nd;
    logic [31:0] rdata;
    dsgate_aph_t aph;
  } dsgate_state_t;

endpackage

// >>> dsgate_props.sv
`timescale 1ns/1ps
`default_nettype none
module dsgate_props (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        HSEL,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        UNIT_ACC,
  input wire logic        UNIT_FAULT,
  input wire logic        IRQ,
  input wire logic [31:0] HADDR,
  input wire logic [31:0] HRDATA,
  input wire logic [1:0]  HTRANS,
  input wire logic [1:0]  MODE,
  input wire logic [2:0]  UNIT_SEL,
  input wire logic [2:0]  UNIT_CLK_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // a taken write address phase; gates move two edges later at the earliest
  wire logic aw = HSEL && HREADY && HTRANS[1] && HWRITE;
  sequence s_hole;
    HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[11:0] == 12'h200;
  endsequence
  a_fault_map: assert property (UNIT_ACC |-> UNIT_FAULT == |(UNIT_SEL & ~UNIT_CLK_EN))
    else $error("fault does not match gating");
  a_fault_idle: assert property (!UNIT_ACC |-> !UNIT_FAULT)
    else $error("fault without access");
  a_resp_okay: assert property (!HRESP) else $error("error response");
  a_zero_wait: assert property (HREADYOUT) else $error("wait state");
  a_reset_off: assert property ($rose(RST_B) |-> UNIT_CLK_EN == 3'h0)
    else $error("unit clocked after reset");
  a_en_steady: assert property ($stable(MODE) && !$past(aw) && !$past(aw, 2) |-> $stable(UNIT_CLK_EN))
    else $error("enable moved without cause");
  a_hole_zero: assert property (s_hole |=> HRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(UNIT_FAULT) || $past(aw, 2))
    else $error("interrupt without cause");
endmodule
bind dsgate_top dsgate_props u_props (
  .REF_CLK     (REF_CLK),
  .RST_B       (RST_B),
  .HSEL        (HSEL),
  .HWRITE      (HWRITE),
  .HREADY      (HREADY),
  .HREADYOUT   (HREADYOUT),
  .HRESP       (HRESP),
  .UNIT_ACC    (UNIT_ACC),
  .UNIT_FAULT  (UNIT_FAULT),
  .IRQ         (IRQ),
  .HADDR       (HADDR),
  .HRDATA      (HRDATA),
  .HTRANS      (HTRANS),
  .MODE        (MODE),
  .UNIT_SEL    (UNIT_SEL),
  .UNIT_CLK_EN (UNIT_CLK_EN)
);
`default_nettype wire

// >>> tb_deep_sleep_clock_gating.sv
`timescale 1ns/1ps
`default_nettype none
module tb_deep_sleep_clock_gating;
  logic        REF_CLK = '0, RST_B = '0, HWRITE = '0, UNIT_ACC = '0, rdp = '0, HSEL = 1'b1;
  logic        HREADYOUT, HRESP, UNIT_FAULT, IRQ;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, r, rg[3], q[$];
  logic [1:0]  HTRANS = '0, MODE = '0;
  logic [2:0]  HSIZE = 3'h2, UNIT_SEL = '0, UNIT_CLK_EN, en;
  int          mismatches, checks_done;
  wire logic   HREADY = HREADYOUT;
  dsgate_top u_dut (.*);
  // 200 MHz system clock
  initial forever #2.5 REF_CLK = ~REF_CLK;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one single transfer; on a read d is the expected word, noted for the monitor
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h0_0000, a};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdp <= !w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rdp <= 1'b0;
  endtask
  // read data is judged at the edge that closes its data phase
  always @(posedge REF_CLK)
    if (rdp === 1'b1) chk(HRDATA, q.pop_front());
  // hang guard, far beyond the planned run length
  initial begin
    repeat (3000) @(posedge REF_CLK);
    mismatches++;
    end_sim;
  end
  initial begin
    void'($urandom(77));
    repeat (4) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    chk(32'(UNIT_CLK_EN), '0);
    ahb(1'b0, 12'h120, dsgate_pkg::DEEP_GATE_RST);
    ahb(1'b0, 12'h200, '0);
    // random enables; reserved bits are written back as they read
    for (int i = 0; i < 3; i++) begin
      r = (i == 2) ? dsgate_pkg::DEEP_GATE_RST : 32'h0000_0000;
      rg[i] = ($urandom & dsgate_pkg::GATE_MASK) | r;
      ahb(1'b1, 12'h100 + 12'(i * 16), rg[i]);
      r = rg[i] & dsgate_pkg::GATE_MASK;
      ahb(1'b0, 12'h100 + 12'(i * 16), r);
    end
    for (int a = 0; a < 2; a++) begin
      ahb(1'b1, 12'h060, 32'(a) << 27);
      for (int m = 0; m < 4; m++) begin
        MODE <= 2'(m);
        r = (a == 1 && m == 1) ? rg[1] : (a == 1 && m == 2) ? rg[2] : rg[0];
        en = {r[20], r[16], r[3]};
        @(negedge REF_CLK);
        chk(32'(UNIT_CLK_EN), 32'(en));
        for (int s = 0; s < 3; s++) begin
          @(posedge REF_CLK);
          UNIT_SEL <= 3'(1 << s);
          UNIT_ACC <= 1'b1;
          @(negedge REF_CLK);
          chk(32'(UNIT_FAULT), 32'(!en[s]));
        end
        @(posedge REF_CLK);
        UNIT_ACC <= 1'b0;
      end
    end
    // faults so far were masked, so the line must stay low
    @(negedge REF_CLK);
    chk(32'(IRQ), '0);
    @(posedge REF_CLK);
    ahb(1'b1, 12'h100, '0);
    ahb(1'b1, 12'h140, 32'h0000_0007);
    ahb(1'b1, 12'h144, 32'h0000_0001);
    UNIT_SEL <= 3'h1;
    UNIT_ACC <= 1'b1;
    @(posedge REF_CLK);
    UNIT_ACC <= 1'b0;
    @(negedge REF_CLK);
    chk(32'(IRQ), 32'h0000_0001);
    @(posedge REF_CLK);
    ahb(1'b0, 12'h140, 32'h0000_0001);
    ahb(1'b1, 12'h140, 32'h0000_0001);
    @(negedge REF_CLK);
    chk(32'(IRQ), '0);
    @(posedge REF_CLK);
    end_sim;
  end
endmodule
`default_nettype wire
